// [src/gpp_pkg.sv]
package gpp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int GPP_NPORT = 8;
    localparam int GPP_NPIN = 31;
    localparam int GPP_NCHAN = 8;
    localparam int GPP_NGRP = 2;

    // ------------------------------------------------------------
    // Register indices on the command port
    // ------------------------------------------------------------
    localparam logic [3:0] GPP_REG_DIR = 4'h0;
    localparam logic [3:0] GPP_REG_MASK = 4'h1;
    localparam logic [3:0] GPP_REG_PIN = 4'h2;
    localparam logic [3:0] GPP_REG_MPIN = 4'h3;
    localparam logic [3:0] GPP_REG_OUT = 4'h4;
    localparam logic [3:0] GPP_REG_SET = 4'h5;
    localparam logic [3:0] GPP_REG_CLR = 4'h6;
    localparam logic [3:0] GPP_REG_IBUF = 4'h7;
    localparam logic [3:0] GPP_REG_PULL = 4'h8;
    localparam logic [3:0] GPP_REG_INT_CFG = 4'h9;
    localparam logic [3:0] GPP_REG_INT_STAT = 4'ha;
    localparam logic [3:0] GPP_REG_GRP0_EN = 4'hb;
    localparam logic [3:0] GPP_REG_GRP1_EN = 4'hc;
    localparam logic [3:0] GPP_REG_GRP_POL = 4'hd;

    // ------------------------------------------------------------
    // Pin interrupt config fields
    // ------------------------------------------------------------
    localparam int GPP_ICFG_PIN_LSB = 0;
    localparam int GPP_ICFG_PORT_LSB = 5;
    localparam int GPP_ICFG_EDGE_BIT = 8;
    localparam int GPP_ICFG_HIGH_BIT = 9;
    localparam int GPP_ICFG_EN_BIT = 10;
    localparam int GPP_ICFG_W = 11;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] GPP_RST_DIR = 32'h0000_0000;
    localparam logic [31:0] GPP_RST_OUT = 32'h0000_0000;
    localparam logic [31:0] GPP_RST_MASK = 32'h0000_0000;
    localparam logic [31:0] GPP_RST_IBUF = 32'h0000_0000;
    localparam logic [31:0] GPP_RST_PULL = 32'hffff_ffff;
    localparam logic [31:0] GPP_RST_GRP = 32'h0000_0000;
    localparam logic [10:0] GPP_RST_ICFG = 11'h000;

endpackage

// [src/gpp_pin_int.sv]
`timescale 1ns/10ps
module gpp_pin_int
    import gpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample,
    input wire logic enable,
    input wire logic edge_mode,
    input wire logic active_high,
    input wire logic clear,
    output logic pending,
    output logic irq
);

    logic prev_reg;
    logic pend_reg;
    logic pend_next;
    logic irq_reg;
    logic evt;

    // ------------------------------------------------------------
    // Edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sample;
        end
    end

    assign evt = enable & edge_mode & (active_high ? (sample & ~prev_reg) : (~sample & prev_reg));
    // Event in the clearing cycle survives
    assign pend_next = (pend_reg & ~clear) | evt;

    // ------------------------------------------------------------
    // Pending flag and request
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else if (edge_mode) begin
            irq_reg <= pend_next;
        end else begin
            irq_reg <= enable & (sample == active_high);
        end
    end

    assign pending = pend_reg;
    assign irq = irq_reg;

endmodule

// [src/gpp_top.sv]
`timescale 1ns/10ps
module gpp_top
    import gpp_pkg::*;
#(
    parameter int NPORT = GPP_NPORT,
    parameter int NPIN = GPP_NPIN
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [2:0] REQ_PORT,
    input wire logic [3:0] REQ_REG,
    input wire logic [3:0] REQ_BE,
    input wire logic [31:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [31:0] RSP_RDATA,
    input wire logic [NPORT*NPIN-1:0] PIN_IN,
    input wire logic [NPORT*NPIN-1:0] PIN_FUNC_CLAIM,
    output logic [NPORT*NPIN-1:0] PIN_OUT,
    output logic [NPORT*NPIN-1:0] PIN_OE,
    output logic [NPORT*NPIN-1:0] PIN_PULLUP,
    output logic [GPP_NCHAN-1:0] PIN_INT,
    output logic [GPP_NGRP-1:0] GRP_INT
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Port select is three bits; bit 31 of each word is kept zero
    if (NPORT < 1 || NPORT > GPP_NPORT || NPIN < 1 || NPIN > GPP_NPIN) begin : g_bad
        $error("gpp_top: NPORT or NPIN out of range");
    end

    logic [NPORT*NPIN-1:0] pin_meta_reg;
    logic [NPORT*NPIN-1:0] pin_sync_reg;
    logic [NPORT*NPIN-1:0] pin_live;
    logic [NPIN-1:0] dir_reg [NPORT];
    logic [NPIN-1:0] out_reg [NPORT];
    logic [NPIN-1:0] mask_reg [NPORT];
    logic [NPIN-1:0] ibuf_reg [NPORT];
    logic [NPIN-1:0] pull_reg [NPORT];
    logic [NPIN-1:0] grp_en_reg [GPP_NGRP][NPORT];
    logic [NPIN-1:0] grp_pol_reg [NPORT];
    logic [GPP_ICFG_W-1:0] icfg_reg [GPP_NCHAN];
    logic [NPIN-1:0] set_bits [NPORT];
    logic [NPIN-1:0] clr_bits [NPORT];
    logic [GPP_NCHAN-1:0] chan_pend;
    logic [GPP_NCHAN-1:0] chan_clr;
    logic [GPP_NGRP-1:0] grp_next;
    logic [GPP_NGRP-1:0] grp_reg;
    logic [31:0] lane_mask;
    logic [NPIN-1:0] wm;
    logic [NPIN-1:0] wd;
    logic wr;
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;
    logic rsp_reg;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= PIN_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign wr = REQ_VALID & REQ_WRITE;
    assign lane_mask = {{8{REQ_BE[3]}}, {8{REQ_BE[2]}}, {8{REQ_BE[1]}}, {8{REQ_BE[0]}}};
    assign wm = lane_mask[NPIN-1:0];
    assign wd = REQ_WDATA[NPIN-1:0];

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic hit;
        assign hit = wr && (REQ_PORT == 3'(p));
        // Buffer off reads as zero, the pad value is not trustworthy
        assign pin_live[p*NPIN +: NPIN] = pin_sync_reg[p*NPIN +: NPIN] & ibuf_reg[p];
        assign PIN_OE[p*NPIN +: NPIN] = dir_reg[p] & ~PIN_FUNC_CLAIM[p*NPIN +: NPIN];
        assign PIN_OUT[p*NPIN +: NPIN] = out_reg[p];
        assign PIN_PULLUP[p*NPIN +: NPIN] = pull_reg[p];

        always_comb begin
            set_bits[p] = '0;
            clr_bits[p] = '0;
            if (hit) begin
                case (REQ_REG)
                    GPP_REG_OUT: begin
                        set_bits[p] = wd & wm;
                        clr_bits[p] = ~wd & wm;
                    end
                    GPP_REG_MPIN: begin
                        set_bits[p] = wd & wm & ~mask_reg[p];
                        clr_bits[p] = ~wd & wm & ~mask_reg[p];
                    end
                    GPP_REG_SET: set_bits[p] = wd & wm;
                    GPP_REG_CLR: clr_bits[p] = wd & wm;
                    default: begin
                        set_bits[p] = '0;
                        clr_bits[p] = '0;
                    end
                endcase
            end
        end

        // ------------------------------------------------------------
        // Port registers
        // ------------------------------------------------------------
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                out_reg[p] <= GPP_RST_OUT[NPIN-1:0];
            end else begin
                out_reg[p] <= (out_reg[p] & ~clr_bits[p]) | set_bits[p];
            end
        end

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                dir_reg[p] <= GPP_RST_DIR[NPIN-1:0];
            end else if (hit && REQ_REG == GPP_REG_DIR) begin
                dir_reg[p] <= (dir_reg[p] & ~wm) | (wd & wm);
            end
        end

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                mask_reg[p] <= GPP_RST_MASK[NPIN-1:0];
            end else if (hit && REQ_REG == GPP_REG_MASK) begin
                mask_reg[p] <= (mask_reg[p] & ~wm) | (wd & wm);
            end
        end

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                ibuf_reg[p] <= GPP_RST_IBUF[NPIN-1:0];
                pull_reg[p] <= GPP_RST_PULL[NPIN-1:0];
            end else begin
                if (hit && REQ_REG == GPP_REG_IBUF) begin
                    ibuf_reg[p] <= (ibuf_reg[p] & ~wm) | (wd & wm);
                end
                if (hit && REQ_REG == GPP_REG_PULL) begin
                    pull_reg[p] <= (pull_reg[p] & ~wm) | (wd & wm);
                end
            end
        end

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                grp_en_reg[0][p] <= GPP_RST_GRP[NPIN-1:0];
                grp_en_reg[1][p] <= GPP_RST_GRP[NPIN-1:0];
                grp_pol_reg[p] <= GPP_RST_GRP[NPIN-1:0];
            end else begin
                if (hit && REQ_REG == GPP_REG_GRP0_EN) begin
                    grp_en_reg[0][p] <= (grp_en_reg[0][p] & ~wm) | (wd & wm);
                end
                if (hit && REQ_REG == GPP_REG_GRP1_EN) begin
                    grp_en_reg[1][p] <= (grp_en_reg[1][p] & ~wm) | (wd & wm);
                end
                if (hit && REQ_REG == GPP_REG_GRP_POL) begin
                    grp_pol_reg[p] <= (grp_pol_reg[p] & ~wm) | (wd & wm);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin interrupt channels
    // ------------------------------------------------------------
    assign chan_clr = (wr && REQ_REG == GPP_REG_INT_STAT) ? REQ_WDATA[7:0] & lane_mask[7:0] : '0;

    for (genvar c = 0; c < GPP_NCHAN; c++) begin : g_chan
        logic [4:0] sel_pin;
        logic [2:0] sel_port;
        logic sel_level;
        assign sel_pin = icfg_reg[c][GPP_ICFG_PIN_LSB +: 5];
        assign sel_port = icfg_reg[c][GPP_ICFG_PORT_LSB +: 3];
        // Any pin of any port; out-of-range selections read low
        assign sel_level = (int'(sel_pin) < NPIN && int'(sel_port) < NPORT) ?
            pin_live[int'(sel_port) * NPIN + int'(sel_pin)] : 1'b0;

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                icfg_reg[c] <= GPP_RST_ICFG;
            end else if (wr && REQ_REG == GPP_REG_INT_CFG && REQ_PORT == 3'(c)) begin
                icfg_reg[c] <= (icfg_reg[c] & ~lane_mask[GPP_ICFG_W-1:0])
                    | (REQ_WDATA[GPP_ICFG_W-1:0] & lane_mask[GPP_ICFG_W-1:0]);
            end
        end

        gpp_pin_int u_int (
            .clk(CLK),
            .rst_n(RST_N),
            .sample(sel_level),
            .enable(icfg_reg[c][GPP_ICFG_EN_BIT]),
            .edge_mode(icfg_reg[c][GPP_ICFG_EDGE_BIT]),
            .active_high(icfg_reg[c][GPP_ICFG_HIGH_BIT]),
            .clear(chan_clr[c]),
            .pending(chan_pend[c]),
            .irq(PIN_INT[c])
        );
    end

    // ------------------------------------------------------------
    // Group interrupts
    // ------------------------------------------------------------
    always_comb begin
        grp_next = '0;
        for (int g = 0; g < GPP_NGRP; g++) begin
            for (int p = 0; p < NPORT; p++) begin
                grp_next[g] = grp_next[g]
                    | (|(grp_en_reg[g][p] & ~(pin_live[p*NPIN +: NPIN] ^ grp_pol_reg[p])));
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            grp_reg <= '0;
        end else begin
            grp_reg <= grp_next;
        end
    end

    assign GRP_INT = grp_reg;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (int'(REQ_PORT) < NPORT) begin
            case (REQ_REG)
                GPP_REG_DIR: rdata_next[NPIN-1:0] = dir_reg[REQ_PORT];
                GPP_REG_MASK: rdata_next[NPIN-1:0] = mask_reg[REQ_PORT];
                GPP_REG_PIN: rdata_next[NPIN-1:0] = pin_live[REQ_PORT*NPIN +: NPIN];
                GPP_REG_MPIN: begin
                    rdata_next[NPIN-1:0] = pin_live[REQ_PORT*NPIN +: NPIN] & ~mask_reg[REQ_PORT];
                end
                GPP_REG_OUT: rdata_next[NPIN-1:0] = out_reg[REQ_PORT];
                GPP_REG_SET: rdata_next[NPIN-1:0] = out_reg[REQ_PORT];
                GPP_REG_IBUF: rdata_next[NPIN-1:0] = ibuf_reg[REQ_PORT];
                GPP_REG_PULL: rdata_next[NPIN-1:0] = pull_reg[REQ_PORT];
                GPP_REG_GRP0_EN: rdata_next[NPIN-1:0] = grp_en_reg[0][REQ_PORT];
                GPP_REG_GRP1_EN: rdata_next[NPIN-1:0] = grp_en_reg[1][REQ_PORT];
                GPP_REG_GRP_POL: rdata_next[NPIN-1:0] = grp_pol_reg[REQ_PORT];
                GPP_REG_INT_CFG: rdata_next[GPP_ICFG_W-1:0] = icfg_reg[REQ_PORT];
                GPP_REG_INT_STAT: rdata_next[GPP_NCHAN-1:0] = chan_pend;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // Narrow reads return zero in the bytes outside the enabled lanes
        rdata_next = rdata_next & lane_mask;
    end

    // Single-cycle answer, no wait states
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsp_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            rsp_reg <= REQ_VALID;
            if (REQ_VALID && !REQ_WRITE) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign RSP_VALID = rsp_reg;
    assign RSP_RDATA = rdata_reg;

endmodule

// [bench/gpp_top_monitor.sv]
`timescale 1ns/10ps
module gpp_top_monitor
    import gpp_pkg::*;
#(
    parameter int NPORT = GPP_NPORT,
    parameter int NPIN = GPP_NPIN
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [2:0] REQ_PORT,
    input wire logic [3:0] REQ_REG,
    input wire logic [3:0] REQ_BE,
    input wire logic [31:0] REQ_WDATA,
    input wire logic RSP_VALID,
    input wire logic [31:0] RSP_RDATA,
    input wire logic [NPORT*NPIN-1:0] PIN_IN,
    input wire logic [NPORT*NPIN-1:0] PIN_FUNC_CLAIM,
    input wire logic [NPORT*NPIN-1:0] PIN_OUT,
    input wire logic [NPORT*NPIN-1:0] PIN_OE,
    input wire logic [NPORT*NPIN-1:0] PIN_PULLUP,
    input wire logic [GPP_NCHAN-1:0] PIN_INT,
    input wire logic [GPP_NGRP-1:0] GRP_INT
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [31:0] lanes;
    logic [NPIN-1:0] wm_pin;
    logic [NPIN-1:0] cur_out;
    function automatic logic [NPIN-1:0] slice(input logic [NPORT*NPIN-1:0] v, input int p);
        return v[p*NPIN +: NPIN];
    endfunction
    assign lanes = {{8{REQ_BE[3]}}, {8{REQ_BE[2]}}, {8{REQ_BE[1]}}, {8{REQ_BE[0]}}};
    assign wm_pin = NPIN'(REQ_WDATA & lanes);
    assign cur_out = slice(PIN_OUT, int'(REQ_PORT));
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence wr_req(logic [3:0] r);
        REQ_VALID && REQ_WRITE && REQ_REG == r;
    endsequence
    sequence rd_req;
        REQ_VALID && !REQ_WRITE;
    endsequence
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rsp_follows_req: assert property (REQ_VALID |=> RSP_VALID)
        else $error("no response one cycle after a request");
    chk_rsp_no_spurious: assert property ($rose(RSP_VALID) |-> $past(REQ_VALID))
        else $error("response without a request");
    chk_oe_claim_low: assert property ((PIN_OE & PIN_FUNC_CLAIM) == '0)
        else $error("claimed pin driven by the port");
    chk_set_bits: assert property (wr_req(GPP_REG_SET) |=> slice(PIN_OUT, int'($past(REQ_PORT)))
        == ($past(cur_out) | $past(wm_pin)))
        else $error("set write gave a wrong latch");
    chk_clr_bits: assert property (wr_req(GPP_REG_CLR) |=> slice(PIN_OUT, int'($past(REQ_PORT)))
        == ($past(cur_out) & ~$past(wm_pin)))
        else $error("clear write gave a wrong latch");
    chk_out_lanes: assert property (wr_req(GPP_REG_OUT) |=> slice(PIN_OUT, int'($past(REQ_PORT)))
        == (($past(cur_out) & ~NPIN'($past(lanes))) | $past(wm_pin)))
        else $error("latch write touched wrong lanes");
    chk_reset_state: assert property ($rose(RST_N) |->
        (&PIN_PULLUP) && PIN_OE == '0 && PIN_OUT == '0)
        else $error("wrong pin state after reset");
    chk_read_lanes: assert property (rd_req |=> ((RSP_RDATA & ~$past(lanes)) == 32'h0)
        && !RSP_RDATA[31])
        else $error("read data outside enabled lanes");
    chk_rdata_hold: assert property ((REQ_VALID && REQ_WRITE) |=> $stable(RSP_RDATA))
        else $error("read data changed on a write");
endmodule

bind gpp_top gpp_top_monitor #(.NPORT(NPORT), .NPIN(NPIN)) u_mon (.CLK(CLK), .RST_N(RST_N),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_PORT(REQ_PORT), .REQ_REG(REQ_REG),
    .REQ_BE(REQ_BE), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .PIN_IN(PIN_IN), .PIN_FUNC_CLAIM(PIN_FUNC_CLAIM), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP(PIN_PULLUP), .PIN_INT(PIN_INT), .GRP_INT(GRP_INT));

// [bench/gpp_board.sv]
`timescale 1ns/10ps
module gpp_board
    import gpp_pkg::*;
#(
    parameter int W = GPP_NPORT * GPP_NPIN
) (
    input wire logic clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pullup,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin_in
);
    // ------------------------------------------------------------
    // Pad level
    // ------------------------------------------------------------
    logic [W-1:0] float_reg;
    // Undriven, unpulled pads wander so a stale level never reads as valid
    always_ff @(posedge clk) begin
        float_reg <= ~pin_in;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | float_reg));
endmodule

// [bench/tb_gpp_top.sv]
`timescale 1ns/10ps
module tb_gpp_top
    import gpp_pkg::*;
;
    localparam int W = GPP_NPORT * GPP_NPIN;
    logic clk, rst_n, req_valid, req_write, rsp_valid;
    logic [2:0] req_port;
    logic [3:0] req_reg, req_be;
    logic [31:0] req_wdata, rsp_rdata, rd;
    logic [W-1:0] pin_in, claim, pin_out, pin_oe, pin_pull, ext_en, ext_val;
    logic [7:0] pin_int;
    logic [1:0] grp_int;
    logic [9:0] irqs;
    int num_errors, checked;
    assign irqs = {grp_int, pin_int};
    gpp_top DUT (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_PORT(req_port), .REQ_REG(req_reg), .REQ_BE(req_be), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .PIN_IN(pin_in), .PIN_FUNC_CLAIM(claim),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pull), .PIN_INT(pin_int),
        .GRP_INT(grp_int));
    gpp_board u_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pull),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] slice(input logic [W-1:0] v, input int p);
        return {1'b0, v[p*31 +: 31]};
    endfunction
    task automatic bus(input logic w, input logic [2:0] p, input logic [3:0] r,
        input logic [3:0] be, input logic [31:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_port <= p;
        req_reg <= r;
        req_be <= be;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        @(negedge clk);
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            num_errors++;
            test_done();
        end
        rd = rsp_rdata;
    endtask
    task automatic wait_irq(input int idx, input logic exp);
        int n;
        n = 0;
        while (irqs[idx] !== exp && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (irqs[idx] !== exp) begin
            num_errors++;
            test_done();
        end
        cmp({31'h0, irqs[idx]}, {31'h0, exp});
    endtask
    // Drives all pins of one port from the board side
    task automatic drive(input int p, input logic [30:0] v);
        @(posedge clk);
        ext_en[p*31 +: 31] <= '1;
        ext_val[p*31 +: 31] <= v;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(negedge clk);
        cmp(slice(pin_pull, 5), 32'h7fff_ffff);
        cmp({31'h0, |pin_oe}, 32'h0);
        bus(1'b0, 3'h0, GPP_REG_PIN, 4'hf, 32'h0);
        cmp(rd, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_dir;
        @(posedge clk);
        claim[93] <= 1'b1;
        bus(1'b1, 3'h3, GPP_REG_DIR, 4'hf, 32'h0000_0005);
        cmp(slice(pin_oe, 3), 32'h0000_0004);
        bus(1'b1, 3'h7, GPP_REG_DIR, 4'hf, 32'h4000_0000);
        cmp(slice(pin_oe, 7), 32'h4000_0000);
        cmp(slice(pin_oe, 3), 32'h0000_0004);
        bus(1'b0, 3'h3, GPP_REG_DIR, 4'hf, 32'h0);
        cmp(rd, 32'h0000_0005);
        $display("test direction done");
    endtask
    task automatic t_out;
        bus(1'b1, 3'h2, GPP_REG_OUT, 4'hf, 32'h1234_5678);
        cmp(slice(pin_out, 2), 32'h1234_5678);
        bus(1'b1, 3'h2, GPP_REG_SET, 4'hf, 32'h4000_0081);
        cmp(slice(pin_out, 2), 32'h5234_56f9);
        bus(1'b1, 3'h2, GPP_REG_CLR, 4'hf, 32'h0000_0018);
        cmp(slice(pin_out, 2), 32'h5234_56e1);
        bus(1'b1, 3'h2, GPP_REG_OUT, 4'h2, 32'hffff_ffff);
        cmp(slice(pin_out, 2), 32'h5234_ffe1);
        bus(1'b0, 3'h2, GPP_REG_OUT, 4'h1, 32'h0);
        cmp(rd, 32'h0000_00e1);
        bus(1'b1, 3'h2, GPP_REG_MASK, 4'hf, 32'hffff_ff00);
        bus(1'b1, 3'h2, GPP_REG_MPIN, 4'hf, 32'h0000_0f0f);
        cmp(slice(pin_out, 2), 32'h5234_ff0f);
        bus(1'b0, 3'h2, 4'hf, 4'hf, 32'h0);
        cmp(rd, 32'h0);
        $display("test output done");
    endtask
    task automatic t_pin_int;
        bus(1'b1, 3'h1, GPP_REG_IBUF, 4'hf, 32'h7fff_ffff);
        drive(1, 31'h0000_02a5);
        repeat (3) @(negedge clk);
        bus(1'b0, 3'h1, GPP_REG_PIN, 4'hf, 32'h0);
        cmp(rd, 32'h0000_02a5);
        bus(1'b1, 3'h1, GPP_REG_MASK, 4'hf, 32'h7fff_ff0f);
        bus(1'b0, 3'h1, GPP_REG_MPIN, 4'hf, 32'h0);
        cmp(rd, 32'h0000_00a0);
        bus(1'b1, 3'h0, GPP_REG_INT_CFG, 4'hf, 32'h0000_0723);
        bus(1'b1, 3'h7, GPP_REG_INT_CFG, 4'hf, 32'h0000_0424);
        wait_irq(7, 1'b1);
        wait_irq(0, 1'b0);
        drive(1, 31'h0000_02bd);
        wait_irq(0, 1'b1);
        wait_irq(7, 1'b0);
        // Falling-edge channel armed while its pin is high
        bus(1'b1, 3'h1, GPP_REG_INT_CFG, 4'hf, 32'h0000_0524);
        drive(1, 31'h0000_02a5);
        repeat (4) @(negedge clk);
        wait_irq(0, 1'b1);
        wait_irq(1, 1'b1);
        bus(1'b0, 3'h0, GPP_REG_INT_STAT, 4'hf, 32'h0);
        cmp(rd, 32'h0000_0003);
        bus(1'b1, 3'h0, GPP_REG_INT_STAT, 4'hf, 32'h0000_0003);
        wait_irq(0, 1'b0);
        wait_irq(1, 1'b0);
        $display("test pin interrupt done");
    endtask
    task automatic t_group;
        wait_irq(8, 1'b0);
        bus(1'b1, 3'h1, GPP_REG_GRP_POL, 4'hf, 32'h0000_0020);
        bus(1'b1, 3'h1, GPP_REG_GRP0_EN, 4'hf, 32'h0000_0020);
        wait_irq(8, 1'b1);
        bus(1'b1, 3'h1, GPP_REG_GRP1_EN, 4'hf, 32'h0000_0040);
        wait_irq(9, 1'b1);
        drive(1, 31'h0000_02e5);
        wait_irq(9, 1'b0);
        $display("test group interrupt done");
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_port = 3'h0;
        req_reg = 4'h0;
        req_be = 4'h0;
        req_wdata = 32'h0;
        claim = '0;
        ext_en = '0;
        ext_val = '0;
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_dir();
        t_out();
        t_pin_int();
        t_group();
        test_done();
    end
endmodule
